// ===== common/dq_pkg.sv
// Purpose: Shared constants and types for the acquisition card registers.
// Assumes: One system clock at 25 MHz; 32-bit register words.
// Notes: Offsets are byte addresses from the card's base address.

package dq_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFF_COUNTER_ZERO = 6'h00;
  localparam logic [5:0] OFF_COUNTER_ONE = 6'h04;
  localparam logic [5:0] OFF_COUNTER_TWO = 6'h08;
  localparam logic [5:0] OFF_COUNTER_MODE = 6'h0C;
  localparam logic [5:0] OFF_ADC_RESULT = 6'h10;
  localparam logic [5:0] OFF_DAC_ONE = 6'h10;
  localparam logic [5:0] OFF_DAC_TWO = 6'h14;
  localparam logic [5:0] OFF_ADC_SETUP = 6'h18;
  localparam logic [5:0] OFF_ADC_FLAGS = 6'h18;
  localparam logic [5:0] OFF_DISCRETE = 6'h1C;
  localparam logic [5:0] OFF_KICK = 6'h20;

  // ---------------------------------------------------------------------
  // Field layouts
  // ---------------------------------------------------------------------
  localparam int SETUP_W = 13;
  localparam int CHAN_W = 4;
  localparam int SAMPLE_W = 12;
  localparam int DAC_W = 12;
  localparam int DIO_W = 16;
  localparam int TIMER_SEL_W = 2;
  localparam int TIMER_SEL_LSB = 2;
  localparam int RESULT_TAG_LSB = 0;
  localparam int RESULT_DATA_LSB = 4;
  localparam int FLAG_READY_BIT = 0;
  localparam int FLAG_OVERRUN_BIT = 1;
  localparam int LOW_BYTE_LANE = 0;
  localparam logic [SETUP_W-1:0] SETUP_RESET = 13'h0000;
  localparam logic [CHAN_W-1:0] CHAN_ZERO = 4'h0;
  localparam logic [CHAN_W-1:0] CHAN_STEP = 4'h1;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Range codes carried on the range output.
  localparam logic [3:0] RANGE_BIP_10V = 4'h8;
  localparam logic [3:0] RANGE_BIP_5V = 4'h0;
  localparam logic [3:0] RANGE_UNI_10V = 4'h4;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned CONV_TIME_NS = 8000;
  // Longest time, so it rounds down.
  localparam int unsigned CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int CONV_CNT_W = 8;
  localparam logic [CONV_CNT_W-1:0] CONV_LAST =
    CONV_CNT_W'(CONV_CYCLES - 1);
  localparam logic [CONV_CNT_W-1:0] CONV_CNT_ZERO = 8'h00;
  localparam logic [CONV_CNT_W-1:0] CONV_CNT_STEP = 8'h01;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } dq_bus_req_t;

  // Packed from bit 12 down to bit 0, as the setup word is laid out.
  typedef struct packed {
    logic [3:0] range_code;
    logic [CHAN_W-1:0] input_channel_select;
    logic auto_scan;
    logic ext_trigger_select;
    logic pacer_soft_choice;
    logic irq_transfer_enable;
    logic busmaster_transfer_enable;
  } dq_setup_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [TIMER_SEL_W-1:0] sel;
    logic [31:0] wdata;
  } dq_timer_req_t;

  typedef enum logic {
    CONV_IDLE,
    CONV_BUSY
  } dq_conv_state_t;

endpackage : dq_pkg

// ===== rtl/dq_sync3.sv
// Purpose: Three-stage synchroniser with agreement filter and rise pulse.
// Assumes: Inputs come from pins outside the clock domain.
// Notes: The first stage feeds only the second stage.

module dq_sync3 #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);

  logic [W-1:0] stage_one;
  logic [W-1:0] stage_two;
  logic [W-1:0] stage_three;
  logic [W-1:0] next_level;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage_one <= '0;
      stage_two <= '0;
      stage_three <= '0;
    end else begin
      stage_one <= pin_in;
      stage_two <= stage_one;
      stage_three <= stage_two;
    end
  end

  // A bit moves only once the two later stages agree.
  always_comb begin
    next_level = (stage_two & ~(stage_two ^ stage_three)) |
                 (level & (stage_two ^ stage_three));
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      level <= '0;
      rise <= '0;
    end else begin
      level <= next_level;
      rise <= next_level & ~level;
    end
  end

endmodule : dq_sync3

// ===== rtl/dq_converter_regs.sv
// Purpose: Register control of a 16-channel, 12-bit acquisition card.
// Assumes: A bus target front end delivers one-cycle word requests.
// Notes: The counter block sits outside and is only decoded; discrete I/O is synchronised and registered here.

module dq_converter_regs (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire dq_pkg::dq_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  output logic bus_rvalid,
  output dq_pkg::dq_timer_req_t timer_req,
  input wire logic [31:0] timer_rdata,
  input wire logic pacer_tick,
  input wire logic outside_trigger_input,
  input wire logic [dq_pkg::DIO_W-1:0] discrete_in,
  output logic [dq_pkg::DIO_W-1:0] discrete_out,
  output logic [dq_pkg::DAC_W-1:0] dac_one_value,
  output logic [dq_pkg::DAC_W-1:0] dac_two_value,
  output logic [dq_pkg::CHAN_W-1:0] input_channel_select,
  output logic [3:0] range_code,
  output logic adc_convert_start,
  input wire logic [dq_pkg::SAMPLE_W-1:0] adc_sample,
  output logic irq_transfer_req,
  output logic busmaster_req,
  input wire logic busmaster_ack
);

  import dq_pkg::*;

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  dq_setup_t setup;
  dq_conv_state_t conv_state;
  logic [CONV_CNT_W-1:0] conv_count;
  logic [CHAN_W-1:0] scan_channel;
  logic [CHAN_W-1:0] conv_tag;
  logic [SAMPLE_W-1:0] result_data;
  logic [CHAN_W-1:0] result_tag;
  logic sample_ready_flag;
  logic sample_overrun_flag;
  logic ext_level;
  logic ext_rise;
  logic [DIO_W-1:0] discrete_level;
  logic wr_dac_one;
  logic wr_dac_two;
  logic wr_setup;
  logic wr_discrete;
  logic wr_kick;
  logic wr_timer;
  logic rd_result_low;
  logic rd_flags;
  logic rd_timer;
  logic trigger_fire;
  logic conv_begin;
  logic conv_done;
  logic next_ready;
  logic next_overrun;
  logic [31:0] next_rdata;
  logic result_unread;
  logic next_unread;
  dq_setup_t setup_word;

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  // Address of a timer register selects one of four timer slots.
  function automatic logic is_timer_addr(input logic [ADDR_W-1:0] a);
    return (a == OFF_COUNTER_ZERO) || (a == OFF_COUNTER_ONE) ||
           (a == OFF_COUNTER_TWO) || (a == OFF_COUNTER_MODE);
  endfunction : is_timer_addr

  // Channel for the conversion after this one.
  function automatic logic [CHAN_W-1:0] scan_step(
    input logic [CHAN_W-1:0] cur,
    input logic [CHAN_W-1:0] top,
    input logic scan
  );
    logic [CHAN_W-1:0] nxt;
    nxt = top;
    if (scan && (cur != CHAN_ZERO)) begin
      nxt = cur - CHAN_STEP;
    end
    return nxt;
  endfunction : scan_step

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  dq_sync3 #(
    .W(1)
  ) u_trig_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in(outside_trigger_input),
    .level(ext_level),
    .rise(ext_rise)
  );

  dq_sync3 #(
    .W(DIO_W)
  ) u_din_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in(discrete_in),
    .level(discrete_level),
    .rise()
  );

  // ---------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------
  // Writes always carry a whole word, so byte enables only matter for
  // spotting the read of the result's low byte.
  always_comb begin
    setup_word = dq_setup_t'(bus_req.wdata[SETUP_W-1:0]);
    wr_dac_one = bus_req.wr && (bus_req.addr == OFF_DAC_ONE);
    wr_dac_two = bus_req.wr && (bus_req.addr == OFF_DAC_TWO);
    wr_setup = bus_req.wr && (bus_req.addr == OFF_ADC_SETUP);
    wr_discrete = bus_req.wr && (bus_req.addr == OFF_DISCRETE);
    wr_kick = bus_req.wr && (bus_req.addr == OFF_KICK);
    wr_timer = bus_req.wr && is_timer_addr(bus_req.addr);
    rd_timer = bus_req.rd && is_timer_addr(bus_req.addr);
    rd_flags = bus_req.rd && (bus_req.addr == OFF_ADC_FLAGS);
    rd_result_low = bus_req.rd && (bus_req.addr == OFF_ADC_RESULT) &&
                    bus_req.be[LOW_BYTE_LANE];
  end

  // ---------------------------------------------------------------------
  // Setup register
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      setup <= dq_setup_t'(SETUP_RESET);
    end else if (wr_setup) begin
      // Bits above the setup field are dropped.
      setup <= setup_word;
    end
  end

  assign range_code = setup.range_code;

  // ---------------------------------------------------------------------
  // Output data registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dac_one_value <= '0;
      dac_two_value <= '0;
    end else begin
      if (wr_dac_one) begin
        dac_one_value <= bus_req.wdata[DAC_W-1:0];
      end
      if (wr_dac_two) begin
        dac_two_value <= bus_req.wdata[DAC_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      discrete_out <= '0;
    end else if (wr_discrete) begin
      discrete_out <= bus_req.wdata[DIO_W-1:0];
    end
  end

  // The counter block is outside; requests are forwarded one cycle late.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_req <= '0;
    end else begin
      timer_req.wr <= wr_timer;
      timer_req.rd <= rd_timer;
      timer_req.sel <= bus_req.addr[TIMER_SEL_LSB +: TIMER_SEL_W];
      timer_req.wdata <= bus_req.wdata;
    end
  end

  // ---------------------------------------------------------------------
  // Trigger selection
  // ---------------------------------------------------------------------
  // A trigger that lands while a conversion runs is dropped; the
  // converter cannot take a second sample before the first finishes.
  always_comb begin
    if (setup.ext_trigger_select) begin
      trigger_fire = ext_rise;
    end else if (setup.pacer_soft_choice) begin
      trigger_fire = pacer_tick;
    end else begin
      trigger_fire = wr_kick;
    end
    conv_begin = trigger_fire && (conv_state == CONV_IDLE);
    conv_done = (conv_state == CONV_BUSY) && (conv_count == CONV_CNT_ZERO);
  end

  // ---------------------------------------------------------------------
  // Multiplexer channel
  // ---------------------------------------------------------------------
  // A setup write takes the multiplexer straight to the new channel,
  // even if a trigger arrives in the same cycle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scan_channel <= CHAN_ZERO;
    end else if (wr_setup) begin
      scan_channel <= setup_word.input_channel_select;
    end else if (conv_begin) begin
      scan_channel <= scan_step(scan_channel,
                                setup.input_channel_select,
                                setup.auto_scan);
    end
  end

  assign input_channel_select = scan_channel;

  // ---------------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      conv_state <= CONV_IDLE;
      conv_count <= CONV_CNT_ZERO;
      conv_tag <= CHAN_ZERO;
    end else begin
      case (conv_state)
        CONV_IDLE: begin
          if (conv_begin) begin
            conv_state <= CONV_BUSY;
            conv_count <= CONV_LAST;
            conv_tag <= scan_channel;
          end
        end
        CONV_BUSY: begin
          if (conv_done) begin
            conv_state <= CONV_IDLE;
          end else begin
            conv_count <= conv_count - CONV_CNT_STEP;
          end
        end
        default: begin
          conv_state <= CONV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      adc_convert_start <= 1'b0;
    end else begin
      adc_convert_start <= conv_begin;
    end
  end

  // The front end holds its sample steady by the end of the window.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      result_data <= '0;
      result_tag <= CHAN_ZERO;
    end else if (conv_done) begin
      result_data <= adc_sample;
      result_tag <= conv_tag;
    end
  end

  // ---------------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------------
  // Completion is applied last so that it wins over any clear.
  always_comb begin
    next_ready = sample_ready_flag;
    if (conv_begin || rd_result_low || busmaster_ack) begin
      next_ready = 1'b0;
    end
    if (conv_done) begin
      next_ready = 1'b1;
    end
  end

  // Ready alone cannot show an unconsumed result, because every start
  // clears it; this flag tracks consumption on its own.
  always_comb begin
    next_unread = result_unread;
    if (rd_result_low || busmaster_ack) begin
      next_unread = 1'b0;
    end
    if (conv_done) begin
      next_unread = 1'b1;
    end
  end

  // An unconsumed result overwritten under bus-master transfer is lost;
  // the flag clears when status is read.
  always_comb begin
    next_overrun = sample_overrun_flag;
    if (rd_flags) begin
      next_overrun = 1'b0;
    end
    if (conv_done && result_unread &&
        setup.busmaster_transfer_enable) begin
      next_overrun = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sample_ready_flag <= 1'b0;
      sample_overrun_flag <= 1'b0;
      result_unread <= 1'b0;
    end else begin
      sample_ready_flag <= next_ready;
      sample_overrun_flag <= next_overrun;
      result_unread <= next_unread;
    end
  end

  // ---------------------------------------------------------------------
  // Transfer requests
  // ---------------------------------------------------------------------
  // Both requests are levels that follow the ready flag; software must
  // not enable both, or the result would be taken twice.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_transfer_req <= 1'b0;
      busmaster_req <= 1'b0;
    end else begin
      irq_transfer_req <= setup.irq_transfer_enable && next_ready;
      busmaster_req <= setup.busmaster_transfer_enable &&
                       next_ready;
    end
  end

  // ---------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------
  always_comb begin
    next_rdata = WORD_ZERO;
    case (bus_req.addr)
      OFF_COUNTER_ZERO, OFF_COUNTER_ONE, OFF_COUNTER_TWO: begin
        next_rdata = timer_rdata;
      end
      OFF_ADC_RESULT: begin
        next_rdata[RESULT_TAG_LSB +: CHAN_W] = result_tag;
        next_rdata[RESULT_DATA_LSB +: SAMPLE_W] = result_data;
      end
      OFF_ADC_FLAGS: begin
        next_rdata[FLAG_READY_BIT] = sample_ready_flag;
        next_rdata[FLAG_OVERRUN_BIT] = sample_overrun_flag;
      end
      OFF_DISCRETE: begin
        next_rdata[DIO_W-1:0] = discrete_level;
      end
      default: begin
        next_rdata = WORD_ZERO;
      end
    endcase
  end

  // Every read returns a full word one cycle after the request.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= WORD_ZERO;
      bus_rvalid <= 1'b0;
    end else begin
      bus_rvalid <= bus_req.rd;
      if (bus_req.rd) begin
        bus_rdata <= next_rdata;
      end
    end
  end

endmodule : dq_converter_regs

// ===== tb/dq_regs_chk_asserts.sv
// Purpose: Port-level checks for the converter register block.
// Assumes: Only the top-level ports are visible here.
// Notes: Bound to every instance of the block at the foot of this file.
module dq_regs_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire dq_pkg::dq_bus_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_rvalid,
  input wire dq_pkg::dq_timer_req_t timer_req,
  input wire logic [dq_pkg::DIO_W-1:0] discrete_out,
  input wire logic [dq_pkg::DAC_W-1:0] dac_one_value,
  input wire logic [dq_pkg::DAC_W-1:0] dac_two_value,
  input wire logic [dq_pkg::CHAN_W-1:0] input_channel_select,
  input wire logic [3:0] range_code,
  input wire logic adc_convert_start,
  input wire logic irq_transfer_req,
  input wire logic busmaster_req
);
  import dq_pkg::*;
  logic [7:0] gap;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // --------------------------------------------------------------------
  // Cycles since the last start; saturates so a long idle never wraps.
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) gap <= 8'hFF;
    else if (adc_convert_start) gap <= 8'h00;
    else if (gap != 8'hFF) gap <= gap + 8'h01;
  end
  property p_rd_answer;
    bus_req.rd |=> bus_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("no read answer");
  property p_rvalid_cause;
    bus_rvalid |-> $past(bus_req.rd);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause)
    else $error("answer without read");
  property p_flag_bits;
    bus_req.rd && bus_req.addr == OFF_ADC_FLAGS |=> bus_rdata[31:2] == 30'h0;
  endproperty
  a_flag_bits: assert property (p_flag_bits)
    else $error("status upper bits set");
  property p_result_bits;
    bus_req.rd && bus_req.addr == OFF_ADC_RESULT
      |=> bus_rdata[31:16] == 16'h0000;
  endproperty
  a_result_bits: assert property (p_result_bits)
    else $error("result upper bits set");
  property p_dac_one;
    bus_req.wr && bus_req.addr == OFF_DAC_ONE
      |=> dac_one_value == $past(bus_req.wdata[11:0]);
  endproperty
  a_dac_one: assert property (p_dac_one) else $error("first output wrong");
  property p_dac_two;
    bus_req.wr && bus_req.addr == OFF_DAC_TWO
      |=> dac_two_value == $past(bus_req.wdata[11:0]);
  endproperty
  a_dac_two: assert property (p_dac_two) else $error("second output wrong");
  property p_setup;
    bus_req.wr && bus_req.addr == OFF_ADC_SETUP
      |=> input_channel_select == $past(bus_req.wdata[8:5])
          && range_code == $past(bus_req.wdata[12:9]);
  endproperty
  a_setup: assert property (p_setup) else $error("setup fields wrong");
  property p_dio;
    bus_req.wr && bus_req.addr == OFF_DISCRETE
      |=> discrete_out == $past(bus_req.wdata[15:0]);
  endproperty
  a_dio: assert property (p_dio) else $error("discrete outputs wrong");
  property p_timer_fwd;
    bus_req.wr && bus_req.addr[5:4] == 2'h0
      |=> timer_req.wr && timer_req.sel == $past(bus_req.addr[3:2]);
  endproperty
  a_timer_fwd: assert property (p_timer_fwd) else $error("counter write lost");
  property p_start_gap;
    adc_convert_start |-> gap >= 8'hC7;
  endproperty
  a_start_gap: assert property (p_start_gap) else $error("start too early");
  property p_start_clears;
    adc_convert_start |=> !irq_transfer_req && !busmaster_req;
  endproperty
  a_start_clears: assert property (p_start_clears)
    else $error("request survives start");
endmodule : dq_regs_chk

bind dq_converter_regs dq_regs_chk u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .timer_req(timer_req),
  .discrete_out(discrete_out), .dac_one_value(dac_one_value),
  .dac_two_value(dac_two_value),
  .input_channel_select(input_channel_select), .range_code(range_code),
  .adc_convert_start(adc_convert_start),
  .irq_transfer_req(irq_transfer_req), .busmaster_req(busmaster_req)
);

// ===== tb/dq_host_model.sv
// Purpose: Host bus master that issues one-word register requests.
// Assumes: Requests change on the falling edge, taken on the rising one.
// Notes: Only the six legal acquisition modes can be programmed.
module dq_host_model (
  input wire logic clk_sys,
  output dq_pkg::dq_bus_req_t bus_req
);
  timeunit 1ns;
  timeprecision 1ns;
  import dq_pkg::*;
  // Legal mode nibbles, index 0 to 5, so no caller can ask for DMA and
  // interrupt at once.
  localparam logic [23:0] MODES = 24'hA98650;
  initial bus_req = '0;
  function automatic logic [3:0] mode_of(input int m);
    return MODES[m*4 +: 4];
  endfunction : mode_of
  task automatic xfer(input logic w, input logic [5:0] a,
                      input logic [31:0] d);
    @(negedge clk_sys);
    bus_req <= '{wr: w, rd: !w, addr: a, be: 4'hF, wdata: d};
    @(negedge clk_sys);
    // Idle lines show the inverse, so a stale address is never reused.
    bus_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, be: 4'h0, wdata: ~d};
  endtask : xfer
  task automatic setup(input int m, input logic [3:0] ch,
                       input logic scan, input logic [3:0] gain);
    logic [31:0] d;
    d = $urandom;
    host_ch_ok: assert (ch <= 4'hF) else $error("channel out of range");
    xfer(1'b1, OFF_ADC_SETUP, {d[31:13], gain, ch, scan, mode_of(m)});
  endtask : setup
endmodule : dq_host_model

// ===== tb/test_dq_converter_regs.sv
// Purpose: Self-checking bench for the converter register block.
// Assumes: Reads answer one cycle after the request edge.
// Notes: Conversions are waited out over the fixed 200-cycle window.
module test_dq_converter_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import dq_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  dq_bus_req_t bus_req;
  dq_timer_req_t timer_req;
  logic [31:0] bus_rdata, timer_rdata, d;
  logic bus_rvalid, pacer_tick, outside_trigger_input, adc_convert_start;
  logic irq_transfer_req, busmaster_req, busmaster_ack;
  logic [DIO_W-1:0] discrete_in, discrete_out;
  logic [DAC_W-1:0] dac_one_value, dac_two_value;
  logic [CHAN_W-1:0] input_channel_select;
  logic [3:0] range_code, md;
  logic [SAMPLE_W-1:0] adc_sample;
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int checked = 0;
  int n_starts = 0;
  always #20 clk_sys = ~clk_sys;
  dq_host_model host (.clk_sys(clk_sys), .bus_req(bus_req));
  dq_converter_regs uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .timer_req(timer_req),
    .timer_rdata(timer_rdata), .pacer_tick(pacer_tick),
    .outside_trigger_input(outside_trigger_input),
    .discrete_in(discrete_in), .discrete_out(discrete_out),
    .dac_one_value(dac_one_value), .dac_two_value(dac_two_value),
    .input_channel_select(input_channel_select), .range_code(range_code),
    .adc_convert_start(adc_convert_start), .adc_sample(adc_sample),
    .irq_transfer_req(irq_transfer_req), .busmaster_req(busmaster_req),
    .busmaster_ack(busmaster_ack)
  );
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // --------------------------------------------------------------------
  // Read answers are matched in order against the noted expectations.
  // --------------------------------------------------------------------
  always @(negedge clk_sys) begin
    if (adc_convert_start === 1'b1) n_starts++;
    if (bus_rvalid === 1'b1 && exp_q.size() == 0) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, bus_rdata, ~bus_rdata);
    end else if (bus_rvalid === 1'b1) begin
      cmp(bus_rdata, exp_q.pop_front());
    end
  end
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic pulse(ref logic s, input int w);
    @(negedge clk_sys);
    s = 1'b1;
    repeat (w) @(negedge clk_sys);
    s = 1'b0;
  endtask : pulse
  // Kind 0 software, 1 pacer, 2 outside pin; the sample only changes when
  // a start is due, so a refused trigger never disturbs the held result.
  task automatic conv(input int kind, input int starts);
    int n0;
    n0 = n_starts;
    if (starts != 0) adc_sample = 12'($urandom);
    if (kind == 0) host.xfer(1'b1, OFF_KICK, $urandom);
    else if (kind == 1) pulse(pacer_tick, 1);
    else pulse(outside_trigger_input, 6);
    repeat (10) @(negedge clk_sys);
    cmp(n_starts, n0 + starts);
    repeat (200) @(negedge clk_sys);
  endtask : conv
  task automatic scan_run(input logic [3:0] ch, input logic scan, int n);
    logic [3:0] t;
    t = ch;
    host.setup(0, ch, scan, 4'h0);
    repeat (n) begin
      conv(0, 1);
      rd(OFF_ADC_FLAGS, 32'h1);
      rd(OFF_ADC_RESULT, {16'h0, adc_sample, t});
      rd(OFF_ADC_FLAGS, 32'h0);
      t = scan ? ((t == 4'h0) ? ch : t - 4'h1) : t;
    end
    $display("scan run done");
  endtask : scan_run
  initial begin
    void'($urandom(23));
    {pacer_tick, outside_trigger_input, busmaster_ack} = 3'h0;
    adc_sample = 12'h000;
    discrete_in = 16'($urandom);
    timer_rdata = $urandom;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    cmp({range_code, input_channel_select, dac_one_value}, 32'h0);
    rd(OFF_ADC_FLAGS, 32'h0);
    rd(6'h24, 32'h0);
    rd(OFF_COUNTER_MODE, 32'h0);
    rd(OFF_DAC_TWO, 32'h0);
    rd(OFF_COUNTER_ONE, timer_rdata);
    rd(OFF_DISCRETE, {16'h0, discrete_in});
    d = $urandom;
    host.xfer(1'b1, OFF_DAC_ONE, d);
    cmp(dac_one_value, d[11:0]);
    host.xfer(1'b1, OFF_DAC_TWO, ~d);
    cmp({dac_two_value, dac_one_value}, {~d[11:0], d[11:0]});
    host.xfer(1'b1, OFF_DISCRETE, d);
    cmp(discrete_out, d[15:0]);
    host.xfer(1'b1, OFF_COUNTER_TWO, d);
    $display("map and outputs done");
    for (int g = 0; g < 9; g++) begin
      md = (g == 8) ? 4'h8 : 4'(g);
      d[3:0] = 4'($urandom);
      host.setup(0, d[3:0], 1'b0, md);
      cmp({range_code, input_channel_select}, {md, d[3:0]});
    end
    rd(OFF_ADC_FLAGS, 32'h0);
    $display("setup fields done");
    scan_run(4'h5, 1'b0, 2);
    scan_run(4'hF, 1'b0, 1);
    scan_run(4'h2, 1'b1, 4);
    for (int m = 0; m < 6; m++) begin
      md = host.mode_of(m);
      host.setup(m, 4'h3, 1'b0, 4'h0);
      conv(0, md[3:2] == 2'b00);
      conv(1, md[3:2] == 2'b01);
      conv(2, md[3]);
      cmp({irq_transfer_req, busmaster_req}, {md[1], md[0]});
      rd(OFF_ADC_FLAGS, 32'h1);
      rd(OFF_ADC_RESULT, {16'h0, adc_sample, 4'h3});
      repeat (2) @(negedge clk_sys);
      cmp({irq_transfer_req, busmaster_req}, 2'b00);
    end
    $display("trigger and transfer modes done");
    host.setup(1, 4'h1, 1'b0, 4'h0);
    conv(1, 1);
    pulse(busmaster_ack, 1);
    repeat (2) @(negedge clk_sys);
    cmp(busmaster_req, 1'b0);
    rd(OFF_ADC_FLAGS, 32'h0);
    conv(1, 1);
    conv(1, 1);
    rd(OFF_ADC_FLAGS, 32'h3);
    rd(OFF_ADC_FLAGS, 32'h1);
    repeat (3) @(negedge clk_sys);
    cmp(exp_q.size(), 0);
    $display("bus master acknowledge done");
    final_report();
  end
endmodule : test_dq_converter_regs
